// file: lml_pkg.sv
// shared constants of the dot-matrix serial loader
// assumes one 100 MHz core clock; all pin inputs are asynchronous to it
package lml_pkg;
    localparam int PIX_BITS = 160;
    localparam int NUM_CHIPS = 2;
    localparam int CTL_BITS = 8;
    localparam int WORD_BITS = 7;
    localparam int WORD_SEL_BIT = 7;
    localparam int SLEEP_BIT = 6;
    localparam int SIMUL_BIT = 0;
    localparam int PRESCALE_BIT = 1;
    localparam int EXT_PRESCALE = 8;
    localparam logic [CTL_BITS-1:0] CTL_RESET = 8'h00;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 7'h00;
    localparam logic TGT_PIXEL = 1'b0;
    localparam logic TGT_CONTROL = 1'b1;
    localparam int CLK_PERIOD_NS = 10;
    localparam int INT_OSC_KHZ = 200;
    localparam int INT_OSC_HALF_CYC = (1_000_000 / CLK_PERIOD_NS) / (2 * INT_OSC_KHZ);
    localparam int SYNC_W = 8;
    // sync bit positions
    localparam int S_CE_N = 0;
    localparam int S_TGT = 1;
    localparam int S_SCLK = 2;
    localparam int S_DIN = 3;
    localparam int S_RST_N = 4;
    localparam int S_DARK = 5;
    localparam int S_OSEL = 6;
    localparam int S_TB = 7;
    // idle pin levels: enable high, device reset asserted
    localparam logic [SYNC_W-1:0] SYNC_RESET = 8'h01;
endpackage

// file: lml_sync2.sv
// two-flop synchroniser for a group of asynchronous pin levels
// assumes each bit is an independent level; no bus coherence implied
module lml_sync2
    import lml_pkg::*;
#(
    parameter int WIDTH = SYNC_W,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } lml_sync_t;

    lml_sync_t st_q;
    lml_sync_t st_d;

    always_comb begin
        st_d.meta = async_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= {RESET_VAL, RESET_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stable;
endmodule

// file: lml_buf2.sv
// two-entry buffer with valid/ready on both sides
// assumes producer honours in_ready_out; output data comes from a flop
module lml_buf2
    import lml_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic [1:0] cnt;
    } lml_buf_t;

    lml_buf_t st_q;
    lml_buf_t st_d;
    logic push;
    logic pop;

    assign in_ready_out = (st_q.cnt != 2'h2);
    assign out_valid_out = (st_q.cnt != 2'h0);
    assign out_data_out = st_q.mem[0];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always_comb begin
        st_d = st_q;
        if (pop) begin
            st_d.mem[0] = st_q.mem[1];
        end
        // new word goes to the first free slot after the pop
        if (push) begin
            if ((st_q.cnt == 2'h0) || ((st_q.cnt == 2'h1) && pop)) begin
                st_d.mem[0] = in_data_in;
            end else begin
                st_d.mem[1] = in_data_in;
            end
        end
        st_d.cnt = 2'(st_q.cnt + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// file: lml_loader.sv
// serial loader and register core of a cascaded dot-matrix LED driver
// assumes all pins asynchronous; shift clock far slower than core clock
module lml_loader
    import lml_pkg::*;
#(
    parameter int NC = NUM_CHIPS,
    parameter int PIX = PIX_BITS,
    parameter int OSC_HALF = INT_OSC_HALF_CYC
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // serial bus pins
    input wire logic chip_enable_n_in,
    input wire logic target_choice_in,
    input wire logic shift_clk_in,
    input wire logic ser_data_in,
    output logic ser_data_out,
    // device control pins
    input wire logic dev_reset_n_in,
    input wire logic darken_display_in,
    input wire logic osc_select_in,
    // two-way timebase pin
    input wire logic timebase_pin_in,
    output logic timebase_pin_out,
    output logic timebase_pin_oe_n_out,
    // display side
    output logic [NC*PIX-1:0] led_out,
    output logic [NC-1:0] sleep_out,
    output logic disp_tick_out,
    output logic [NC*WORD_BITS-1:0] word0_out,
    output logic [NC*WORD_BITS-1:0] word1_out,
    // stream of bits shifted out of the chain
    output logic shout_valid_out,
    output logic shout_bit_out,
    input wire logic shout_ready_in,
    output logic shout_room_out
);
    localparam int OSC_W = $clog2(OSC_HALF);
    localparam int PRE_W = $clog2(EXT_PRESCALE);
    localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_HALF - 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(EXT_PRESCALE - 1);

    typedef struct packed {
        logic [NC-1:0][PIX-1:0] pix;
        logic [NC-1:0][PIX-1:0] latch;
        logic [NC-1:0][PIX-1:0] led;
        logic [NC-1:0][CTL_BITS-1:0] cshift;
        logic [NC-1:0][WORD_BITS-1:0] w0;
        logic [NC-1:0][WORD_BITS-1:0] w1;
        logic sel;
        logic pend;
        logic clk_p;
        logic ce_p;
        logic tb_p;
        logic dout;
        logic osc;
        logic tick;
        logic [OSC_W-1:0] osc_cnt;
        logic [PRE_W-1:0] pre_cnt;
    } lml_state_t;

    lml_state_t st_q;
    lml_state_t st_d;
    logic [SYNC_W-1:0] pins_s;
    logic ce_s, tgt_s, sclk_s, din_s, rst_n_s, dark_s, osel_s, tb_s;
    logic sclk_rise, ce_fall, shift_ev, latch_ev, tgt_now, tb_rise, osc_run;
    logic [NC-1:0] chip_in;
    logic [NC-1:0] chip_out;
    logic [NC-1:0] awake;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection
    lml_sync2 #(
        .WIDTH(SYNC_W),
        .RESET_VAL(SYNC_RESET)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .async_in({timebase_pin_in, osc_select_in, darken_display_in, dev_reset_n_in,
                   ser_data_in, shift_clk_in, target_choice_in, chip_enable_n_in}),
        .sync_out(pins_s)
    );

    assign ce_s = pins_s[S_CE_N];
    assign tgt_s = pins_s[S_TGT];
    assign sclk_s = pins_s[S_SCLK];
    assign din_s = pins_s[S_DIN];
    assign rst_n_s = pins_s[S_RST_N];
    assign dark_s = pins_s[S_DARK];
    assign osel_s = pins_s[S_OSEL];
    assign tb_s = pins_s[S_TB];

    assign sclk_rise = sclk_s & ~st_q.clk_p;
    assign ce_fall = st_q.ce_p & ~ce_s;
    // shift only on a rising shift clock while enable is low
    assign shift_ev = sclk_rise & ~ce_s;
    // copy once per frame: enable back high and shift clock low
    assign latch_ev = ce_s & ~sclk_s & st_q.pend;
    // destination taken from the level held at enable fall
    assign tgt_now = ce_fall ? tgt_s : st_q.sel;
    assign tb_rise = tb_s & ~st_q.tb_p;

    ////////////////////////////////////////////////////////////////////
    // per-chip serial path; chip i is fed from chip i-1
    for (genvar i = 0; i < NC; i++) begin : g_chip
        if (i == 0) begin : g_first
            assign chip_in[i] = din_s;
        end else begin : g_next
            assign chip_in[i] = chip_out[i-1];
        end
        // far end of the selected chain, or pass-through for control data in simultaneous mode
        assign chip_out[i] = (tgt_now == TGT_PIXEL) ? st_q.pix[i][PIX-1] :
                             (st_q.w1[i][SIMUL_BIT] ? chip_in[i] :
                              st_q.cshift[i][CTL_BITS-1]);
        // word 0 sleep bit low means asleep
        assign awake[i] = st_q.w0[i][SLEEP_BIT];
        assign sleep_out[i] = ~awake[i];
        assign word0_out[i*WORD_BITS +: WORD_BITS] = st_q.w0[i];
        assign word1_out[i*WORD_BITS +: WORD_BITS] = st_q.w1[i];
    end

    // internal oscillator stops once every chip sleeps
    assign osc_run = osel_s & (|awake);

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d = st_q;
        st_d.clk_p = sclk_s;
        st_d.ce_p = ce_s;
        st_d.tb_p = tb_s;
        st_d.tick = 1'b0;
        if (ce_fall) begin
            st_d.sel = tgt_s;
            st_d.pend = 1'b1;
        end
        for (int i = 0; i < NC; i++) begin
            if (shift_ev) begin
                // low choice feeds pixels, high choice feeds control
                if (tgt_now == TGT_PIXEL) begin
                    st_d.pix[i] = {st_q.pix[i][PIX-2:0], chip_in[i]};
                end else begin
                    st_d.cshift[i] = {st_q.cshift[i][CTL_BITS-2:0], chip_in[i]};
                end
            end
            if (latch_ev) begin
                if (st_q.sel == TGT_PIXEL) begin
                    st_d.latch[i] = st_q.pix[i];
                end else if (st_q.cshift[i][WORD_SEL_BIT]) begin
                    st_d.w1[i] = st_q.cshift[i][WORD_BITS-1:0];
                end else begin
                    st_d.w0[i] = st_q.cshift[i][WORD_BITS-1:0];
                end
            end
            // pin reset clears control only; pixel chain left alone
            if (!rst_n_s) begin
                st_d.cshift[i] = CTL_RESET;
                st_d.w0[i] = WORD_RESET;
                st_d.w1[i] = WORD_RESET;
            end
            // one bit per LED; darkened or asleep forces all off
            if (dark_s || !st_d.w0[i][SLEEP_BIT]) begin
                st_d.led[i] = '0;
            end else begin
                st_d.led[i] = st_d.latch[i];
            end
        end
        if (latch_ev) begin
            st_d.pend = 1'b0;
        end
        st_d.dout = chip_out[NC-1];
        // display timebase: internal divider or external pin
        if (osc_run) begin
            if (st_q.osc_cnt == OSC_LAST) begin
                st_d.osc_cnt = '0;
                st_d.osc = ~st_q.osc;
                st_d.tick = ~st_q.osc;
            end else begin
                st_d.osc_cnt = st_q.osc_cnt + 1'b1;
            end
        end else begin
            st_d.osc_cnt = '0;
            st_d.osc = 1'b0;
        end
        if (!osel_s && tb_rise) begin
            if (st_q.w1[0][PRESCALE_BIT]) begin
                st_d.pre_cnt = st_q.pre_cnt + 1'b1;
                st_d.tick = (st_q.pre_cnt == PRE_LAST);
            end else begin
                st_d.pre_cnt = '0;
                st_d.tick = 1'b1;
            end
        end
    end

    // pixel chain and latches keep whatever they hold through reset
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q.led <= '0;
            st_q.cshift <= '0;
            st_q.w0 <= '0;
            st_q.w1 <= '0;
            st_q.sel <= TGT_PIXEL;
            st_q.pend <= 1'b0;
            st_q.clk_p <= 1'b0;
            st_q.ce_p <= 1'b1;
            st_q.tb_p <= 1'b0;
            st_q.dout <= 1'b0;
            st_q.osc <= 1'b0;
            st_q.tick <= 1'b0;
            st_q.osc_cnt <= '0;
            st_q.pre_cnt <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign led_out = st_q.led;
    assign ser_data_out = st_q.dout;
    assign disp_tick_out = st_q.tick;
    // pin driven only when the internal oscillator is chosen
    assign timebase_pin_out = st_q.osc;
    assign timebase_pin_oe_n_out = ~osel_s;

    lml_buf2 #(
        .WIDTH(1)
    ) u_shout (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .in_valid_in(shift_ev),
        .in_data_in(chip_out[NC-1]),
        .in_ready_out(shout_room_out),
        .out_valid_out(shout_valid_out),
        .out_data_out(shout_bit_out),
        .out_ready_in(shout_ready_in)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_frame_open;
        ce_fall ##1 !ce_s;
    endsequence

    property p_rst_ctl;
        !rst_n_s |=> (st_q.w0 == '0) && (st_q.w1 == '0) && (st_q.cshift == '0);
    endproperty
    a_rst_ctl: assert property (p_rst_ctl) else $error("control not cleared");

    property p_rst_dark;
        !rst_n_s |=> (led_out == '0) && sleep_out[0];
    endproperty
    a_rst_dark: assert property (p_rst_dark) else $error("reset did not darken");

    property p_shift_px;
        shift_ev && (tgt_now == TGT_PIXEL) |=> st_q.pix[0][0] == $past(din_s);
    endproperty
    a_shift_px: assert property (p_shift_px) else $error("pixel bit not shifted");

    property p_no_shift;
        sclk_rise && ce_s |=> $stable(st_q.pix) && $stable(st_q.cshift);
    endproperty
    a_no_shift: assert property (p_no_shift) else $error("shift with enable high");

    property p_sel_cap;
        s_frame_open |-> st_q.sel == $past(tgt_s);
    endproperty
    a_sel_cap: assert property (p_sel_cap) else $error("target not captured");

    property p_latch;
        latch_ev && (st_q.sel == TGT_PIXEL) |=> st_q.latch == $past(st_q.pix);
    endproperty
    a_latch: assert property (p_latch) else $error("pixels not copied");

    property p_hold;
        !latch_ev |=> $stable(st_q.latch);
    endproperty
    a_hold: assert property (p_hold) else $error("latch changed early");

    property p_word;
        latch_ev && rst_n_s && (st_q.sel == TGT_CONTROL) && st_q.cshift[0][WORD_SEL_BIT]
            |=> (st_q.w1[0] == $past(st_q.cshift[0][WORD_BITS-1:0])) && $stable(st_q.w0[0]);
    endproperty
    a_word: assert property (p_word) else $error("wrong control word");

    property p_dark;
        dark_s |=> led_out == '0;
    endproperty
    a_dark: assert property (p_dark) else $error("darken ignored");

    property p_dout;
        shift_ev && (tgt_now == TGT_PIXEL) && (st_q.sel == TGT_PIXEL) && !ce_fall
            |-> ##2 ser_data_out == $past(st_q.pix[NC-1][PIX-2], 2);
    endproperty
    a_dout: assert property (p_dout) else $error("far-end bit wrong");

    property p_osc_dir;
        osel_s |-> !timebase_pin_oe_n_out;
    endproperty
    a_osc_dir: assert property (p_osc_dir) else $error("pin not driven");

    property p_osc_stop;
        !osc_run |=> !timebase_pin_out;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("oscillator ran asleep");
endmodule

// file: lml_host.sv
// host model that drives the serial write pins of the loader
// assumes the bench calls open_frame, shift and close_frame in that order
module lml_host
    import lml_pkg::*;
(
    // serial bus pins
    output logic ce_n_out,
    output logic tgt_out,
    output logic sclk_out,
    output logic din_out,
    // chained data back from the loader
    input wire logic sdo_in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] seen = 16'h0000;

    // shift clock stands low outside frames
    initial begin
        ce_n_out = 1'b1;
        tgt_out = TGT_PIXEL;
        sclk_out = 1'b0;
        din_out = 1'b0;
    end

    task automatic open_frame(input logic tgt);
        tgt_out = tgt;
        #23 ce_n_out = 1'b0; // target set up before enable falls
        #23 tgt_out = ~tgt; // later target changes must not matter
        #43;
    endtask

    // msb first, data line inverted once its hold time is over
    task automatic shift(input logic [15:0] d, input int n);
        for (int k = n - 1; k >= 0; k--) begin
            din_out = d[k];
            #62.5 sclk_out = 1'b1;
            #62.5 sclk_out = 1'b0;
            din_out = ~d[k];
            #33 seen = {seen[14:0], sdo_in};
        end
    endtask

    // enable rises only while the clock is low
    task automatic close_frame();
        #23 ce_n_out = 1'b1;
        #103;
    endtask
endmodule

// file: test_led_matrix_serial_loader.sv
// self-checking bench of the serial loader, two chips of eight pixels
// assumes lml_host drives the serial pins; the bench drives the rest
module test_led_matrix_serial_loader;
    import lml_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        logic tgt;
        int n;
        logic [15:0] d;
        logic [15:0] led;
        logic [13:0] w0;
        logic [13:0] w1;
    } lml_row_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce_n, tgt, sclk, din, sdo, tick, tb_out, tb_oe_n, sv, sb, sroom;
    logic dev_rst_n = 1'b1;
    logic dark = 1'b0;
    logic osel = 1'b0;
    logic ext = 1'b0;
    logic srdy = 1'b1;
    logic tb_wire;
    logic [15:0] led;
    logic [1:0] sleep;
    logic [13:0] w0, w1;
    int compares = 0;
    int miscompares = 0;
    int ticks = 0;
    int togs = 0;
    int drained;
    logic last_tb = 1'b0;
    lml_row_t rows[10];

    // timebase wire level from both drivers
    assign tb_wire = tb_oe_n ? ext : tb_out;

    always #5 clk = ~clk;

    always @(posedge clk) begin
        ticks <= ticks + int'(tick);
        togs <= togs + int'(tb_out !== last_tb);
        last_tb <= tb_out;
    end

    lml_host host (.ce_n_out(ce_n), .tgt_out(tgt), .sclk_out(sclk), .din_out(din),
        .sdo_in(sdo));

    lml_loader #(.NC(2), .PIX(8), .OSC_HALF(4)) uut (
        .core_clk_in(clk), .rst_in(rst), .chip_enable_n_in(ce_n), .target_choice_in(tgt),
        .shift_clk_in(sclk), .ser_data_in(din), .ser_data_out(sdo),
        .dev_reset_n_in(dev_rst_n), .darken_display_in(dark), .osc_select_in(osel),
        .timebase_pin_in(tb_wire), .timebase_pin_out(tb_out),
        .timebase_pin_oe_n_out(tb_oe_n), .led_out(led), .sleep_out(sleep),
        .disp_tick_out(tick), .word0_out(w0), .word1_out(w1), .shout_valid_out(sv),
        .shout_bit_out(sb), .shout_ready_in(srdy), .shout_room_out(sroom));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic load(input logic t, input logic [15:0] d, input int n);
        host.open_frame(t);
        host.shift(d, n);
        host.close_frame();
        @(negedge clk);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic ext_edges(input int n);
        repeat (2 * n) begin
            wait_cyc(5);
            ext = ~ext;
        end
        wait_cyc(6);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{
            '{TGT_PIXEL, 16, 16'h0000, 16'h0000, 14'h0000, 14'h0000},
            '{TGT_CONTROL, 16, 16'h4040, 16'h0000, {7'h40, 7'h40}, 14'h0000},
            '{TGT_PIXEL, 16, 16'ha5c3, 16'ha5c3, {7'h40, 7'h40}, 14'h0000},
            '{TGT_CONTROL, 16, 16'h8282, 16'ha5c3, {7'h40, 7'h40}, {7'h02, 7'h02}},
            '{TGT_PIXEL, 16, 16'h0001, 16'h0001, {7'h40, 7'h40}, {7'h02, 7'h02}},
            '{TGT_CONTROL, 16, 16'h4a00, 16'h0000, {7'h4a, 7'h00}, {7'h02, 7'h02}},
            '{TGT_CONTROL, 16, 16'h4040, 16'h0001, {7'h40, 7'h40}, {7'h02, 7'h02}},
            '{TGT_CONTROL, 16, 16'h8181, 16'h0001, {7'h40, 7'h40}, {7'h01, 7'h01}},
            '{TGT_CONTROL, 8, 16'h0045, 16'h0001, {7'h45, 7'h45}, {7'h01, 7'h01}},
            '{TGT_CONTROL, 8, 16'h0080, 16'h0001, {7'h45, 7'h45}, 14'h0000}};
        repeat (10) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        wait_cyc(4);
        chk("word0 reset", 16'h0000, {2'b00, w0});
        chk("sleep reset", 16'h0003, {14'h0000, sleep});
        chk("led reset", 16'h0000, led);
        chk("stream reset", 16'h0000, {15'h0000, sv});
        // zero fill first, then wake through word 0
        foreach (rows[i]) begin
            load(rows[i].tgt, rows[i].d, rows[i].n);
            chk("led", rows[i].led, led);
            chk("word0", {2'b00, rows[i].w0}, {2'b00, w0});
            chk("word1", {2'b00, rows[i].w1}, {2'b00, w1});
        end
        dark = 1'b1;
        wait_cyc(5);
        chk("led dark", 16'h0000, led);
        dark = 1'b0;
        dev_rst_n = 1'b0;
        wait_cyc(8);
        chk("word0 pin reset", 16'h0000, {2'b00, w0});
        chk("word1 pin reset", 16'h0000, {2'b00, w1});
        chk("led pin reset", 16'h0000, led);
        dev_rst_n = 1'b1;
        wait_cyc(4);
        load(TGT_CONTROL, 16'h4040, 16);
        chk("led kept", 16'h0001, led);
        host.open_frame(TGT_PIXEL);
        host.shift(16'hffff, 16);
        @(negedge clk);
        chk("led held", 16'h0001, led);
        chk("dout", 16'h0003, host.seen);
        host.close_frame();
        @(negedge clk);
        chk("led new", 16'hffff, led);
        // stall the stream: two bits held, the third refused
        srdy = 1'b0;
        host.open_frame(TGT_PIXEL);
        host.shift(16'h0000, 3);
        @(negedge clk);
        chk("room full", 16'h0000, {15'h0000, sroom});
        chk("valid full", 16'h0001, {15'h0000, sv});
        host.close_frame();
        @(negedge clk);
        chk("led shifted", 16'hfff8, led);
        srdy = 1'b1;
        drained = 0;
        for (int k = 0; k < 10; k++) begin
            if (sv === 1'b1) begin
                drained++;
                chk("stream bit", 16'h0001, {15'h0000, sb});
            end
            @(negedge clk);
        end
        chk("drained", 16'h0002, 16'(drained));
        osel = 1'b1;
        wait_cyc(6);
        togs = 0;
        wait_cyc(200);
        chk("oe internal", 16'h0000, {15'h0000, tb_oe_n});
        chk("osc toggles", 16'h0001, {15'h0000, 1'(togs >= 49 && togs <= 51)});
        osel = 1'b0;
        wait_cyc(6);
        chk("oe external", 16'h0001, {15'h0000, tb_oe_n});
        ticks = 0;
        ext_edges(16);
        chk("ticks direct", 16'h0010, 16'(ticks));
        load(TGT_CONTROL, 16'h8282, 16);
        ticks = 0;
        ext_edges(16);
        chk("ticks prescaled", 16'h0002, 16'(ticks));
        load(TGT_CONTROL, 16'h0000, 16);
        chk("led asleep", 16'h0000, led);
        osel = 1'b1;
        wait_cyc(6);
        togs = 0;
        wait_cyc(100);
        chk("osc asleep", 16'h0000, 16'(togs));
        close_out();
    end
endmodule
